// ==== logic/mem_access_pkg.sv ====
// shared constants and carriers for the memory space access unit
package mem_access_pkg;
    localparam int DATA_W = 16;
    localparam int EA_W = 16;
    localparam int PADDR_W = 24;
    localparam int PROG_W = 24;
    localparam int DMEM_WORDS = 768;
    localparam int NEAR_FIELD_W = 13;
    localparam int DMEM_IDX_W = 10;
    localparam int EA_PSV_BIT = 15;
    localparam logic [15:0] SPECIAL_TOP = 16'h07FF;
    localparam logic [15:0] NEAR_TOP = 16'h1FFF;
    localparam logic [15:0] SPECIAL_BASE_WORDS = 16'h0400;
    localparam logic [23:0] RESET_VEC = 24'h000000;
    localparam logic [23:0] RESET_TGT = 24'h000002;
    localparam logic [23:0] IVT_LO = 24'h000004;
    localparam logic [23:0] IVT_HI = 24'h0000FF;
    localparam logic [23:0] AIVT_LO = 24'h000104;
    localparam logic [23:0] AIVT_HI = 24'h0001FF;
    localparam logic [23:0] VEC_END = 24'h000200;
    localparam logic [23:0] PC_STEP = 24'h000002;
    localparam logic [15:0] STEP_BYTE = 16'h0001;
    localparam logic [15:0] STEP_WORD = 16'h0002;
    localparam logic [23:0] CFG_BOOT = 24'hF80000;
    localparam logic [23:0] CFG_GEN = 24'hF80004;
    localparam logic [23:0] CFG_OSCSEL = 24'hF80006;
    localparam logic [23:0] CFG_OSC = 24'hF80008;
    localparam logic [23:0] CFG_WDT = 24'hF8000A;
    localparam logic [23:0] CFG_POR = 24'hF8000C;
    localparam logic [23:0] CFG_DBG = 24'hF8000E;
    localparam logic [23:0] CFG_DSLP = 24'hF80010;

    typedef enum logic [1:0] {
        PC_HOLD = 2'b00,
        PC_INC = 2'b01,
        PC_DEC = 2'b10,
        PC_LOAD = 2'b11
    } pc_op_t;

    typedef enum logic [1:0] {
        EXT_NONE = 2'b00,
        EXT_SIGN = 2'b01,
        EXT_ZERO = 2'b10
    } ext_op_t;

    typedef struct packed {
        logic [1:0] vec_kind;
        logic [2:0] cfg_idx;
        logic cfg_hit;
        logic upper_word;
    } prog_dec_t;

    typedef struct packed {
        logic [23:0] pc;
        prog_dec_t pdec;
        logic [15:0] rd_data;
        logic [15:0] wreg;
        logic [15:0] rd_ptr;
        logic [15:0] wr_ptr;
        logic psv_sel;
        logic near_hit;
        logic addr_trap;
        logic special_sel;
    } state_t;
endpackage : mem_access_pkg

// ==== logic/mem_access_unit.sv ====
// program and data space decode, byte lanes, data memory and address trap
`timescale 1ns/1ps
// Functional notes
// - program word is 24 bits, lower/upper halves
// - pc word aligned, steps by two
// - vectors below 000200h, reset at zero
// - two interrupt vector tables decoded
// - eight configuration word addresses decoded
// - separate read and write address generators
// - 16-bit byte effective addresses
// - bit 15 selects program space window
// - 768 words; outside reads return zero
// - low byte even, high byte odd
// - pointer post-step one byte, two word
// - byte read selects lane, low lane out
// - shared word decode, separate lane strobes
// - odd word access traps, write suppressed
// - byte load keeps register high byte
// - sign extend and zero extend ops
// - near region reached by 13-bit field
// - full 16-bit direct move address
// - all memory inside near region
// - special register space low 2 Kbytes
// - control bit gates program window flag; window reads give zero
module mem_access_unit #(
    parameter int MEM_WORDS = mem_access_pkg::DMEM_WORDS
) (
    input wire logic CLK, // core clock
    input wire logic RST_N, // async reset, low
    input wire mem_access_pkg::pc_op_t PC_OP, // program counter action
    input wire logic [23:0] PC_TARGET, // load target
    input wire logic [23:0] PROG_ADDR, // program address to classify
    input wire logic RD_EN, // read request
    input wire logic RD_BYTE, // read is byte sized
    input wire logic RD_POSTINC, // post-step read pointer
    input wire logic RD_DIRECT, // read uses direct field
    input wire logic RD_NEAR_FORM, // direct field is 13-bit form
    input wire logic [15:0] RD_FIELD, // direct address field
    input wire logic WR_EN, // write request
    input wire logic WR_BYTE, // write is byte sized
    input wire logic WR_POSTINC, // post-step write pointer
    input wire logic WR_DIRECT, // write uses direct field
    input wire logic WR_NEAR_FORM, // direct field is 13-bit form
    input wire logic [15:0] WR_FIELD, // direct address field
    input wire logic [15:0] WR_DATA, // store data
    input wire logic PTR_LOAD, // load both pointers
    input wire logic [15:0] PTR_VALUE, // pointer load value
    input wire logic PSV_ENABLE, // core control window enable
    input wire logic LOAD_WREG, // load read data into register
    input wire mem_access_pkg::ext_op_t EXT_OP, // extend op on register
    output logic [23:0] PC, // program counter
    output logic PROG_UPPER, // address is upper word
    output logic PROG_CFG_HIT, // address is a config word
    output logic [2:0] PROG_CFG_IDX, // which config word
    output logic [1:0] PROG_VEC_KIND, // 0 none 1 reset 2 ivt 3 alt
    output logic [15:0] RD_DATA, // read data
    output logic [15:0] WREG, // working register
    output logic [15:0] RD_PTR, // read pointer
    output logic [15:0] WR_PTR, // write pointer
    output logic PSV_SEL, // last read hit program window
    output logic NEAR_HIT, // last read was in near region
    output logic SPECIAL_SEL, // last read in special space
    output logic ADDR_TRAP // misaligned word pulse
);
    // the word index is cut to the index width, so the memory may not outgrow it
    if (MEM_WORDS < 1 || MEM_WORDS * 2 > 32'h2000 - 32'h0800 ||
        MEM_WORDS > (1 << mem_access_pkg::DMEM_IDX_W)) begin : g_bad_size
        $error("memory must fit the near region above special space");
    end

    logic [15:0] mem_lo [MEM_WORDS];
    logic [15:0] mem_hi [MEM_WORDS];
    mem_access_pkg::state_t st_ff;
    mem_access_pkg::state_t nxt_st;
    logic [15:0] rd_ea;
    logic [15:0] wr_ea;
    logic rd_trap;
    logic wr_trap;
    logic wr_lo_stb;
    logic wr_hi_stb;
    logic [15:0] rd_word;

    // memory word index, or all ones when the address is unimplemented
    function automatic logic [15:0] mem_index(input logic [15:0] ea);
        logic [15:0] w;
        w = {1'b0, ea[15:1]};
        if (ea[mem_access_pkg::EA_PSV_BIT]) begin
            mem_index = 16'hFFFF;
        end else if (w >= mem_access_pkg::SPECIAL_BASE_WORDS &&
                     w < mem_access_pkg::SPECIAL_BASE_WORDS + 16'(MEM_WORDS)) begin
            mem_index = w - mem_access_pkg::SPECIAL_BASE_WORDS;
        end else begin
            mem_index = 16'hFFFF;
        end
    endfunction : mem_index

    function automatic logic [15:0] gen_ea(input logic direct, input logic near_form,
                                           input logic [15:0] field, input logic [15:0] ptr);
        if (!direct) begin
            gen_ea = ptr;
        end else if (near_form) begin
            gen_ea = {3'h0, field[mem_access_pkg::NEAR_FIELD_W-1:0]};
        end else begin
            gen_ea = field;
        end
    endfunction : gen_ea

    function automatic logic [15:0] ptr_step(input logic is_byte);
        ptr_step = is_byte ? mem_access_pkg::STEP_BYTE : mem_access_pkg::STEP_WORD;
    endfunction : ptr_step

    always_comb begin
        logic [15:0] ri;
        logic [15:0] wi;
        logic [15:0] bsel;
        // addresses first: the index lookups below must see this cycle's addresses
        rd_ea = gen_ea(RD_DIRECT, RD_NEAR_FORM, RD_FIELD, st_ff.rd_ptr);
        wr_ea = gen_ea(WR_DIRECT, WR_NEAR_FORM, WR_FIELD, st_ff.wr_ptr);
        ri = mem_index(rd_ea);
        wi = mem_index(wr_ea);
        bsel = 16'h0000;
        rd_trap = RD_EN && !RD_BYTE && rd_ea[0];
        wr_trap = WR_EN && !WR_BYTE && wr_ea[0];
        wr_lo_stb = WR_EN && !wr_trap && (!WR_BYTE || !wr_ea[0]);
        wr_hi_stb = WR_EN && !wr_trap && (!WR_BYTE || wr_ea[0]);
        // unimplemented and program-window reads give zero, whether or not the window is enabled
        rd_word = 16'h0000;
        if (ri != 16'hFFFF) begin
            rd_word = {mem_hi[ri[mem_access_pkg::DMEM_IDX_W-1:0]][7:0],
                       mem_lo[ri[mem_access_pkg::DMEM_IDX_W-1:0]][7:0]};
        end
        nxt_st = st_ff;
        unique case (PC_OP)
            mem_access_pkg::PC_HOLD: nxt_st.pc = st_ff.pc;
            mem_access_pkg::PC_INC: nxt_st.pc = st_ff.pc + mem_access_pkg::PC_STEP;
            mem_access_pkg::PC_DEC: nxt_st.pc = st_ff.pc - mem_access_pkg::PC_STEP;
            mem_access_pkg::PC_LOAD: nxt_st.pc = {PC_TARGET[23:1], 1'b0};
        endcase
        nxt_st.pdec.upper_word = PROG_ADDR[0];
        nxt_st.pdec.cfg_hit = 1'b0;
        nxt_st.pdec.cfg_idx = 3'h0;
        unique case (PROG_ADDR)
            mem_access_pkg::CFG_BOOT: {nxt_st.pdec.cfg_hit, nxt_st.pdec.cfg_idx} = 4'h8;
            mem_access_pkg::CFG_GEN: {nxt_st.pdec.cfg_hit, nxt_st.pdec.cfg_idx} = 4'h9;
            mem_access_pkg::CFG_OSCSEL: {nxt_st.pdec.cfg_hit, nxt_st.pdec.cfg_idx} = 4'hA;
            mem_access_pkg::CFG_OSC: {nxt_st.pdec.cfg_hit, nxt_st.pdec.cfg_idx} = 4'hB;
            mem_access_pkg::CFG_WDT: {nxt_st.pdec.cfg_hit, nxt_st.pdec.cfg_idx} = 4'hC;
            mem_access_pkg::CFG_POR: {nxt_st.pdec.cfg_hit, nxt_st.pdec.cfg_idx} = 4'hD;
            mem_access_pkg::CFG_DBG: {nxt_st.pdec.cfg_hit, nxt_st.pdec.cfg_idx} = 4'hE;
            mem_access_pkg::CFG_DSLP: {nxt_st.pdec.cfg_hit, nxt_st.pdec.cfg_idx} = 4'hF;
            default: ;
        endcase
        if (PROG_ADDR >= mem_access_pkg::IVT_LO && PROG_ADDR <= mem_access_pkg::IVT_HI) begin
            nxt_st.pdec.vec_kind = 2'h2;
        end else if (PROG_ADDR >= mem_access_pkg::AIVT_LO &&
                     PROG_ADDR <= mem_access_pkg::AIVT_HI) begin
            nxt_st.pdec.vec_kind = 2'h3;
        end else if (PROG_ADDR < mem_access_pkg::VEC_END) begin
            nxt_st.pdec.vec_kind = 2'h1;
        end else begin
            nxt_st.pdec.vec_kind = 2'h0;
        end
        nxt_st.addr_trap = rd_trap || wr_trap;
        if (RD_EN) begin
            // window reads return zero until program fetch path is wired in
            nxt_st.psv_sel = rd_ea[mem_access_pkg::EA_PSV_BIT] && PSV_ENABLE;
            nxt_st.near_hit = rd_ea <= mem_access_pkg::NEAR_TOP;
            nxt_st.special_sel = rd_ea <= mem_access_pkg::SPECIAL_TOP;
            if (RD_BYTE) begin
                bsel = {8'h00, rd_ea[0] ? rd_word[15:8] : rd_word[7:0]};
                nxt_st.rd_data = bsel;
            end else begin
                nxt_st.rd_data = rd_word; // read still completes
            end
        end
        if (LOAD_WREG && RD_EN) begin
            if (RD_BYTE) begin
                nxt_st.wreg = {st_ff.wreg[15:8], bsel[7:0]};
            end else begin
                nxt_st.wreg = rd_word;
            end
        end else begin
            unique case (EXT_OP)
                mem_access_pkg::EXT_SIGN: nxt_st.wreg = {{8{st_ff.wreg[7]}}, st_ff.wreg[7:0]};
                mem_access_pkg::EXT_ZERO: nxt_st.wreg = {8'h00, st_ff.wreg[7:0]};
                default: nxt_st.wreg = st_ff.wreg;
            endcase
        end
        if (PTR_LOAD) begin
            nxt_st.rd_ptr = PTR_VALUE;
            nxt_st.wr_ptr = PTR_VALUE;
        end else begin
            if (RD_EN && RD_POSTINC && !RD_DIRECT) begin
                nxt_st.rd_ptr = st_ff.rd_ptr + ptr_step(RD_BYTE);
            end
            if (WR_EN && WR_POSTINC && !WR_DIRECT) begin
                nxt_st.wr_ptr = st_ff.wr_ptr + ptr_step(WR_BYTE);
            end
        end
        if (wi == 16'hFFFF) begin
            nxt_st.special_sel = nxt_st.special_sel;
        end
    end

    // lanes are separate arrays so a byte write touches one side only
    always_ff @(posedge CLK) begin
        logic [15:0] wi;
        wi = mem_index(wr_ea);
        if (wi != 16'hFFFF) begin
            if (wr_lo_stb) begin
                mem_lo[wi[mem_access_pkg::DMEM_IDX_W-1:0]] <= {8'h00, WR_DATA[7:0]};
            end
            if (wr_hi_stb) begin
                mem_hi[wi[mem_access_pkg::DMEM_IDX_W-1:0]] <=
                    {8'h00, WR_BYTE ? WR_DATA[7:0] : WR_DATA[15:8]};
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            st_ff <= '0;
            st_ff.pc <= mem_access_pkg::RESET_VEC;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign PC = st_ff.pc;
    assign PROG_UPPER = st_ff.pdec.upper_word;
    assign PROG_CFG_HIT = st_ff.pdec.cfg_hit;
    assign PROG_CFG_IDX = st_ff.pdec.cfg_idx;
    assign PROG_VEC_KIND = st_ff.pdec.vec_kind;
    assign RD_DATA = st_ff.rd_data;
    assign WREG = st_ff.wreg;
    assign RD_PTR = st_ff.rd_ptr;
    assign WR_PTR = st_ff.wr_ptr;
    assign PSV_SEL = st_ff.psv_sel;
    assign NEAR_HIT = st_ff.near_hit;
    assign SPECIAL_SEL = st_ff.special_sel;
    assign ADDR_TRAP = st_ff.addr_trap;
endmodule : mem_access_unit

// ==== test/core_model.sv ====
// core-side request model: issues data reads and writes, notes expected read data
`timescale 1ns/1ps
module core_model (
    input wire logic clk, // core clock
    output logic rd_en, // read request
    output logic rd_byte, // byte read
    output logic rd_dir, // direct read
    output logic rd_near, // 13-bit field form
    output logic [15:0] rd_field, // read address
    output logic ld_wreg, // load register
    output logic wr_en, // write request
    output logic wr_byte, // byte write
    output logic [15:0] wr_field, // write address
    output logic [15:0] wr_data // store data
);
    logic [15:0] exp_q[$];
    initial {rd_en, rd_byte, rd_dir, rd_near, rd_field, ld_wreg} = '0;
    initial {wr_en, wr_byte, wr_field, wr_data} = '0;
    // one call owns one edge; the request stands until the next call replaces it
    task automatic op(input logic r, w, b, d, n, l, input logic [15:0] a, x, e);
        @(negedge clk);
        {rd_en, wr_en, rd_byte, wr_byte, rd_dir, rd_near, ld_wreg} = {r, w, b, b, d, n, l};
        rd_field = a;
        wr_field = a;
        wr_data = x;
        if (r) exp_q.push_back(e);
    endtask : op
endmodule : core_model

// ==== test/mem_access_unit_asserts.sv ====
// timing checks on the memory space access unit ports
`timescale 1ns/1ps
module mem_access_unit_asserts (
    input wire logic CLK, // clock
    input wire logic RST_N, // reset
    input wire mem_access_pkg::pc_op_t PC_OP, // pc action
    input wire logic [23:0] PROG_ADDR, // program address
    input wire logic RD_EN, // read
    input wire logic RD_BYTE, // byte read
    input wire logic RD_DIRECT, // direct read
    input wire logic RD_NEAR_FORM, // short field
    input wire logic [15:0] RD_FIELD, // read field
    input wire logic WR_EN, // write
    input wire logic WR_BYTE, // byte write
    input wire logic WR_DIRECT, // direct write
    input wire logic WR_NEAR_FORM, // short field
    input wire logic [15:0] WR_FIELD, // write field
    input wire logic [15:0] WR_DATA, // store data
    input wire logic PSV_ENABLE, // window enable
    input wire logic PSV_SEL, // window flag
    input wire logic NEAR_HIT, // near flag
    input wire logic SPECIAL_SEL, // special flag
    input wire logic LOAD_WREG, // load register
    input wire mem_access_pkg::ext_op_t EXT_OP, // extend op
    input wire logic [23:0] PC, // pc
    input wire logic PROG_CFG_HIT, // config hit
    input wire logic [2:0] PROG_CFG_IDX, // config index
    input wire logic [1:0] PROG_VEC_KIND, // vector class
    input wire logic [15:0] RD_DATA, // read data
    input wire logic [15:0] WREG, // register
    input wire logic ADDR_TRAP // trap pulse
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    sequence s_wr_word;
        WR_EN && WR_DIRECT && !WR_NEAR_FORM && !WR_BYTE && !WR_FIELD[0]
            && WR_FIELD inside {[16'h0800:16'h0DFE]};
    endsequence
    sequence s_rd_same;
        RD_EN && RD_DIRECT && !RD_NEAR_FORM && !RD_BYTE && !WR_EN
            && RD_FIELD == $past(WR_FIELD);
    endsequence
    chk_store_then_read: assert property (s_wr_word ##1 s_rd_same |=>
        RD_DATA == $past(WR_DATA, 2)) else $error("stored word not read back");
    chk_odd_read_trap: assert property (RD_EN && RD_DIRECT && !RD_NEAR_FORM && !RD_BYTE
        && RD_FIELD[0] |=> ADDR_TRAP) else $error("odd word read did not trap");
    chk_idle_no_trap: assert property (!RD_EN && !WR_EN |=> !ADDR_TRAP)
        else $error("trap without access");
    chk_pc_inc_two: assert property (PC_OP == mem_access_pkg::PC_INC |=>
        PC == $past(PC) + 24'h000002) else $error("pc increment not two");
    chk_pc_dec_two: assert property (PC_OP == mem_access_pkg::PC_DEC |=>
        PC == $past(PC) - 24'h000002) else $error("pc decrement not two");
    chk_cfg_debug_idx: assert property (PROG_ADDR == mem_access_pkg::CFG_DBG |=>
        PROG_CFG_HIT && PROG_CFG_IDX == 3'h6) else $error("debug config not decoded");
    chk_alt_vec_kind: assert property (PROG_ADDR inside {[24'h000104:24'h0001FF]} |=>
        PROG_VEC_KIND == 2'h3) else $error("alternate table not decoded");
    chk_window_read_zero: assert property (RD_EN && RD_DIRECT && !RD_NEAR_FORM
        && RD_FIELD[15] |=> RD_DATA == 16'h0000) else $error("window read not zero");
    chk_sign_extend: assert property (EXT_OP == mem_access_pkg::EXT_SIGN && !LOAD_WREG |=>
        WREG == {{8{$past(WREG[7])}}, $past(WREG[7:0])}) else $error("sign extend wrong");
    chk_byte_load_high: assert property (LOAD_WREG && RD_EN && RD_BYTE
        && EXT_OP == mem_access_pkg::EXT_NONE |=> WREG[15:8] == $past(WREG[15:8]))
        else $error("byte load changed high byte");
    chk_window_flag: assert property (RD_EN && RD_DIRECT && !RD_NEAR_FORM && RD_FIELD[15]
        |=> PSV_SEL == $past(PSV_ENABLE)) else $error("window flag wrong");
    chk_near_flag: assert property (RD_EN && RD_DIRECT && !RD_NEAR_FORM
        |=> NEAR_HIT == ($past(RD_FIELD) <= 16'h1FFF)) else $error("near flag wrong");
    chk_special_flag: assert property (RD_EN && RD_DIRECT && !RD_NEAR_FORM
        |=> SPECIAL_SEL == ($past(RD_FIELD) <= 16'h07FF)) else $error("special flag wrong");
endmodule : mem_access_unit_asserts
bind mem_access_unit mem_access_unit_asserts i_chk (.*);

// ==== test/mem_access_unit_test.sv ====
// self-checking bench for the memory space access unit
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module mem_access_unit_test;
    logic clk, rst_n, ptr_load, psv_en, rd_seen, rd_post, upper, cfg_hit, addr_trap;
    logic rd_en, rd_byte, rd_dir, rd_near, ld_wreg, wr_en, wr_byte;
    mem_access_pkg::pc_op_t pc_op;
    mem_access_pkg::ext_op_t ext_op;
    logic [23:0] pc, pc_tgt, prog_addr;
    logic [15:0] rd_field, wr_field, wr_data, rd_data, wreg, rd_ptr, wr_ptr, ptr_val, d, w, e;
    logic [2:0] cfg_idx;
    logic [1:0] vec_kind;
    logic [31:0] seed = 32'h00000026;
    logic [15:0] m[logic [15:0]];
    logic [15:0] wa[5] = '{16'h0E00, 16'h8000, 16'h0800, 16'h0802, 16'h0DFE};
    logic [15:0] ra[6] = '{16'h0DFE, 16'h0800, 16'h0802, 16'h0E00, 16'h8000, 16'h0400};
    logic [23:0] va[4] = '{24'h000000, 24'h000005, 24'h000105, 24'h000201};
    logic [1:0] vk[4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    int num_errors = 0;
    int checks_done = 0;
    assign rd_post = ~rd_dir;
    core_model i_core (.clk(clk), .rd_en(rd_en), .rd_byte(rd_byte), .rd_dir(rd_dir),
        .rd_near(rd_near), .rd_field(rd_field), .ld_wreg(ld_wreg), .wr_en(wr_en),
        .wr_byte(wr_byte), .wr_field(wr_field), .wr_data(wr_data));
    mem_access_unit i_dut (.CLK(clk), .RST_N(rst_n), .PC_OP(pc_op), .PC_TARGET(pc_tgt),
        .PROG_ADDR(prog_addr), .RD_EN(rd_en), .RD_BYTE(rd_byte), .RD_POSTINC(rd_post),
        .RD_DIRECT(rd_dir), .RD_NEAR_FORM(rd_near), .RD_FIELD(rd_field), .WR_EN(wr_en),
        .WR_BYTE(wr_byte), .WR_POSTINC(1'b0), .WR_DIRECT(1'b1), .WR_NEAR_FORM(1'b0),
        .WR_FIELD(wr_field), .WR_DATA(wr_data), .PTR_LOAD(ptr_load), .PTR_VALUE(ptr_val),
        .PSV_ENABLE(psv_en), .LOAD_WREG(ld_wreg), .EXT_OP(ext_op), .PC(pc),
        .PROG_UPPER(upper), .PROG_CFG_HIT(cfg_hit), .PROG_CFG_IDX(cfg_idx),
        .PROG_VEC_KIND(vec_kind), .RD_DATA(rd_data), .WREG(wreg), .RD_PTR(rd_ptr),
        .WR_PTR(wr_ptr), .PSV_SEL(), .NEAR_HIT(), .SPECIAL_SEL(), .ADDR_TRAP(addr_trap));
    always #2 clk = ~clk;
    // a read result lands one edge after the request
    always @(posedge clk) rd_seen <= rd_en & rst_n;
    always @(negedge clk) if (rd_seen) begin
        e = i_core.exp_q.pop_front();
        `CHK(rd_data, e)
    end
    function automatic logic [15:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction : rnd
    task automatic idle();
        i_core.op(0, 0, 0, 0, 0, 0, 16'h0000, 16'h0000, 16'h0000);
        @(posedge clk);
        #1;
    endtask : idle
    task automatic prog(input logic [23:0] a);
        @(negedge clk);
        prog_addr = a;
        @(posedge clk);
        #1;
    endtask : prog
    task automatic pcs(input mem_access_pkg::pc_op_t op, input logic [23:0] x);
        @(negedge clk);
        pc_op = op;
        pc_tgt = 24'h000123;
        @(posedge clk);
        #1;
        `CHK(pc, x)
    endtask : pcs
    task automatic conclude();
        $display("mismatches %0d comparisons %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude
    initial begin
        {clk, rst_n, ptr_load, pc_tgt, prog_addr} = '0;
        {pc_op, ext_op, psv_en, ptr_val} = {mem_access_pkg::PC_HOLD, mem_access_pkg::EXT_NONE,
            1'b1, 16'h0800};
        repeat (8) @(negedge clk);
        rst_n = 1;
        `CHK(pc, 24'h000000)
        foreach (wa[i]) begin
            d = rnd();
            i_core.op(0, 1, 0, 1, 0, 0, wa[i], d, 16'h0000);
            if (wa[i] < 16'h0E00) m[wa[i]] = d;
        end
        foreach (ra[i]) i_core.op(1, 0, 0, 1, 0, 0, ra[i], 16'h0000,
            m.exists(ra[i]) ? m[ra[i]] : 16'h0000);
        psv_en = 0;
        i_core.op(1, 0, 0, 1, 0, 0, 16'h8000, 16'h0000, 16'h0000);
        psv_en = 1;
        i_core.op(1, 0, 1, 1, 0, 0, 16'h0801, 16'h0000, {8'h00, m[16'h0800][15:8]});
        i_core.op(0, 1, 1, 1, 0, 0, 16'h0801, d, 16'h0000);
        m[16'h0800][15:8] = d[7:0];
        i_core.op(1, 0, 0, 1, 0, 0, 16'h0800, 16'h0000, m[16'h0800]);
        i_core.op(0, 1, 0, 1, 0, 0, 16'h0DFF, 16'hFFFF, 16'h0000);
        @(posedge clk);
        #1;
        `CHK(addr_trap, 1'b1)
        i_core.op(1, 0, 0, 1, 0, 0, 16'h0803, 16'h0000, m[16'h0802]);
        @(posedge clk);
        #1;
        `CHK(addr_trap, 1'b1)
        i_core.op(1, 0, 0, 1, 0, 0, 16'h0DFE, 16'h0000, m[16'h0DFE]);
        i_core.op(1, 0, 0, 1, 1, 0, 16'hE800, 16'h0000, m[16'h0800]);
        i_core.op(1, 0, 0, 1, 0, 1, 16'h0802, 16'h0000, m[16'h0802]);
        i_core.op(0, 1, 1, 1, 0, 0, 16'h0802, 16'h0085, 16'h0000);
        w = {m[16'h0802][15:8], 8'h85};
        m[16'h0802][7:0] = 8'h85;
        i_core.op(1, 0, 1, 1, 0, 1, 16'h0802, 16'h0000, 16'h0085);
        idle();
        `CHK(wreg, w)
        @(negedge clk);
        ext_op = mem_access_pkg::EXT_SIGN;
        @(negedge clk);
        ext_op = mem_access_pkg::EXT_ZERO;
        `CHK(wreg, 16'hFF85)
        @(negedge clk);
        ext_op = mem_access_pkg::EXT_NONE;
        ptr_load = 1;
        `CHK(wreg, 16'h0085)
        @(negedge clk);
        ptr_load = 0;
        i_core.op(1, 0, 0, 0, 0, 0, 16'h0000, 16'h0000, m[16'h0800]);
        i_core.op(1, 0, 1, 0, 0, 0, 16'h0000, 16'h0000, 16'h0085);
        idle();
        `CHK({rd_ptr, wr_ptr}, {16'h0803, 16'h0800})
        pcs(mem_access_pkg::PC_LOAD, 24'h000122);
        pcs(mem_access_pkg::PC_INC, 24'h000124);
        pcs(mem_access_pkg::PC_DEC, 24'h000122);
        pcs(mem_access_pkg::PC_HOLD, 24'h000122);
        for (int i = 0; i < 8; i++) begin
            prog(i == 0 ? 24'hF80000 : 24'hF80002 + 24'(2 * i));
            `CHK({cfg_hit, cfg_idx}, {1'b1, 3'(i)})
        end
        foreach (va[i]) begin
            prog(va[i]);
            `CHK({upper, vec_kind}, {va[i][0], vk[i]})
        end
        conclude();
    end
    // the whole sequence needs well under a thousand cycles
    initial begin
        #(4 * 5000);
        num_errors++;
        conclude();
    end
endmodule : mem_access_unit_test
